/* File: rtl/hcps_config_regs.sv */
// Hub configuration bank, bytes 0x0e to 0x53: currents, power-on time,
// language code, string lengths and the maker string.
// Assumes a byte-wide register port on clk, loaded from the configuration
// memory or the management port; self_powered arrives from a pin.
`timescale 1ns/1ps
`include "hcps_defs.svh"

module hcps_config_regs
  import hcps_pkg::*;
#(
  parameter int PG_TICK_CYCLES = `HCPS_PG_UNIT_MS * `HCPS_CLK_KHZ,
  parameter int TEXT_BYTES = `HCPS_TEXT_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic self_powered,
  output logic [7:0] ctrl_current_report,
  output logic [15:0] language_code,
  output logic [7:0] maker_text_length,
  output logic [7:0] item_text_length,
  output logic [7:0] serial_text_length,
  input wire logic [4:0] char_index,
  output logic [15:0] char_data,
  input wire logic port_power_start,
  output logic [7:0] port_power_good_delay,
  output logic port_power_good
);

  logic [7:0] cur_self_r;
  logic [7:0] cur_bus_r;
  logic [7:0] pg_delay_r;
  logic [7:0] lang_up_r;
  logic [7:0] lang_lo_r;
  logic [7:0] maker_len_r;
  logic [7:0] item_len_r;
  logic [7:0] serial_len_r;
  logic [7:0] text_mem [0:TEXT_BYTES-1];
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic [15:0] char_r;
  logic sp_meta_r;
  logic sp_sync_r;

  // Address decode
  wire sel_cur_self = (reg_addr == `HCPS_OFS_CUR_SELF);
  wire sel_cur_bus = (reg_addr == `HCPS_OFS_CUR_BUS);
  wire sel_pg = (reg_addr == `HCPS_OFS_PG_DELAY);
  wire sel_lang_up = (reg_addr == `HCPS_OFS_LANG_UP);
  wire sel_lang_lo = (reg_addr == `HCPS_OFS_LANG_LO);
  wire sel_maker_len = (reg_addr == `HCPS_OFS_MAKER_LEN);
  wire sel_item_len = (reg_addr == `HCPS_OFS_ITEM_LEN);
  wire sel_serial_len = (reg_addr == `HCPS_OFS_SERIAL_LEN);
  wire sel_text = (reg_addr >= `HCPS_OFS_TEXT_FIRST) &&
                  (reg_addr <= `HCPS_OFS_TEXT_LAST);
  wire [7:0] text_off = reg_addr - `HCPS_OFS_TEXT_FIRST;
  wire [5:0] text_idx = text_off[5:0];
  wire text_wr = reg_wr_en && sel_text;

  // Counts above 31 characters are held at 31
  wire [7:0] len_wr = (reg_wr_data > `HCPS_TEXT_LEN_MAX) ?
                      `HCPS_TEXT_LEN_MAX : reg_wr_data;

  // Unmapped offsets read as zero
  wire [7:0] rd_mux =
    sel_cur_self ? cur_self_r :
    sel_cur_bus ? cur_bus_r :
    sel_pg ? pg_delay_r :
    sel_lang_up ? lang_up_r :
    sel_lang_lo ? lang_lo_r :
    sel_maker_len ? maker_len_r :
    sel_item_len ? item_len_r :
    sel_serial_len ? serial_len_r :
    sel_text ? text_mem[text_idx] :
    `HCPS_RST_ZERO;

  // Character n sits at bytes 2n (low) and 2n+1 (high)
  // Index 31 lies past the 62-byte area and reads as zero
  wire char_ok = (char_index != `HCPS_CHAR_IDX_LIMIT);
  wire [5:0] char_lo_idx = {char_index, 1'b0};
  wire [5:0] char_hi_idx = {char_index, 1'b1};
  wire [15:0] char_nxt = char_ok ?
    {text_mem[char_hi_idx], text_mem[char_lo_idx]} : 16'h0000;

  // Currents and power-on time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_self_r <= `HCPS_RST_CUR;
      cur_bus_r <= `HCPS_RST_CUR;
      pg_delay_r <= `HCPS_RST_ZERO;
    end else if (reg_wr_en) begin
      if (sel_cur_self) begin
        cur_self_r <= reg_wr_data;
      end
      if (sel_cur_bus) begin
        cur_bus_r <= reg_wr_data;
      end
      if (sel_pg) begin
        pg_delay_r <= reg_wr_data;
      end
    end
  end

  // Language code bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lang_up_r <= `HCPS_RST_ZERO;
      lang_lo_r <= `HCPS_RST_ZERO;
    end else if (reg_wr_en) begin
      if (sel_lang_up) begin
        lang_up_r <= reg_wr_data;
      end
      if (sel_lang_lo) begin
        lang_lo_r <= reg_wr_data;
      end
    end
  end

  // Length registers store the clamped count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maker_len_r <= `HCPS_RST_ZERO;
      item_len_r <= `HCPS_RST_ZERO;
      serial_len_r <= `HCPS_RST_ZERO;
    end else if (reg_wr_en) begin
      if (sel_maker_len) begin
        maker_len_r <= len_wr;
      end
      if (sel_item_len) begin
        item_len_r <= len_wr;
      end
      if (sel_serial_len) begin
        serial_len_r <= len_wr;
      end
    end
  end

  // Maker string bytes, one flop group per address
  genvar gi;
  generate
    for (gi = 0; gi < TEXT_BYTES; gi++) begin : g_text
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          text_mem[gi] <= `HCPS_RST_ZERO;
        end else if (text_wr && text_idx == 6'(gi)) begin
          text_mem[gi] <= reg_wr_data;
        end
      end
    end
  endgenerate

  // Read port: data held until the next read, valid pulses once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= `HCPS_RST_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Character output lags char_index by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_r <= 16'h0000;
    end else begin
      char_r <= char_nxt;
    end
  end

  // Powering-mode pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_meta_r <= 1'b0;
      sp_sync_r <= 1'b0;
    end else begin
      sp_meta_r <= self_powered;
      sp_sync_r <= sp_meta_r;
    end
  end

  // Port power-on sequence timer
  hcps_power_good_timer #(
    .TICK_CYCLES(PG_TICK_CYCLES)
  ) u_pg_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(port_power_start),
    .delay_units(pg_delay_r),
    .power_good(port_power_good)
  );

  // Reported current follows the synchronised powering mode
  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;
  assign ctrl_current_report = sp_sync_r ? cur_self_r : cur_bus_r;
  assign language_code = {lang_up_r, lang_lo_r};
  assign maker_text_length = maker_len_r;
  assign item_text_length = item_len_r;
  assign serial_text_length = serial_len_r;
  assign char_data = char_r;
  assign port_power_good_delay = pg_delay_r;

endmodule

/* File: rtl/hcps_defs.svh */
// Offsets, reset values and timing figures of the hub configuration bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HCPS_DEFS_SVH
`define HCPS_DEFS_SVH

`define HCPS_OFS_CUR_SELF 8'h0e
`define HCPS_OFS_CUR_BUS 8'h0f
`define HCPS_OFS_PG_DELAY 8'h10
`define HCPS_OFS_LANG_UP 8'h11
`define HCPS_OFS_LANG_LO 8'h12
`define HCPS_OFS_MAKER_LEN 8'h13
`define HCPS_OFS_ITEM_LEN 8'h14
`define HCPS_OFS_SERIAL_LEN 8'h15
`define HCPS_OFS_TEXT_FIRST 8'h16
`define HCPS_OFS_TEXT_LAST 8'h53

`define HCPS_RST_CUR 8'h32
`define HCPS_RST_ZERO 8'h00
`define HCPS_TEXT_LEN_MAX 8'h1f
`define HCPS_TEXT_BYTES 62
`define HCPS_CHAR_IDX_LIMIT 5'h1f

`define HCPS_PG_UNIT_MS 2
`define HCPS_CLK_KHZ 125000

`endif

/* File: rtl/hcps_pkg.sv */
// Types shared by the hub configuration bank and its power-good timer.
// Assumes hcps_defs.svh is on the include path.
`include "hcps_defs.svh"

package hcps_pkg;

  typedef enum logic [1:0] {
    HCPS_PG_IDLE,
    HCPS_PG_WAIT,
    HCPS_PG_GOOD
  } hcps_pg_state_t;

endpackage

/* File: rtl/hcps_power_good_timer.sv */
// Port power-good timer: counts the programmed delay in 2 ms units.
// Assumes start is a one-cycle pulse on clk; delay is held meanwhile.
`timescale 1ns/1ps
`include "hcps_defs.svh"

module hcps_power_good_timer
  import hcps_pkg::*;
#(
  parameter int TICK_CYCLES = `HCPS_PG_UNIT_MS * `HCPS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] delay_units,
  output logic power_good
);

  hcps_pg_state_t state_r;
  hcps_pg_state_t state_nxt;
  logic [31:0] div_r;
  logic [7:0] units_r;
  logic tick;
  logic done;

  // One-cycle enable every 2 ms while waiting
  assign tick = (state_r == HCPS_PG_WAIT) && (div_r == 32'(TICK_CYCLES - 1));
  assign done = (units_r == 8'h00) || (tick && units_r == 8'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HCPS_PG_IDLE: begin
        if (start) begin
          state_nxt = HCPS_PG_WAIT;
        end
      end
      HCPS_PG_WAIT: begin
        if (start) begin
          state_nxt = HCPS_PG_WAIT;
        end else if (done) begin
          state_nxt = HCPS_PG_GOOD;
        end
      end
      HCPS_PG_GOOD: begin
        if (start) begin
          state_nxt = HCPS_PG_WAIT;
        end
      end
      default: state_nxt = HCPS_PG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HCPS_PG_IDLE;
      div_r <= 32'h0000_0000;
      units_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (start || tick) begin
        div_r <= 32'h0000_0000;
      end else if (state_r == HCPS_PG_WAIT) begin
        div_r <= div_r + 32'h0000_0001;
      end
      if (start) begin
        units_r <= delay_units;
      end else if (tick && units_r != 8'h00) begin
        units_r <= units_r - 8'h01;
      end
    end
  end

  assign power_good = (state_r == HCPS_PG_GOOD);

endmodule

/* File: sim/hcps_config_regs_asserts.sv */
// Port checker for the hub configuration bank.
// Assumes it is bound into hcps_config_regs.
`timescale 1ns/1ps
module hcps_config_regs_asserts #(
  parameter int PG_TICK_CYCLES = 250000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic self_powered,
  input wire logic [7:0] ctrl_current_report,
  input wire logic [15:0] language_code,
  input wire logic [7:0] maker_text_length,
  input wire logic port_power_start,
  input wire logic [7:0] port_power_good_delay,
  input wire logic port_power_good
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_cur_reset: assert property (
    $rose(rst_n) |-> ctrl_current_report == 8'h32) else $error("cur reset");
  chk_report_self: assert property (
    self_powered[*4] ##0 reg_rd_en && reg_addr == 8'h0e && !$past(reg_wr_en)
    |=> reg_rd_data == $past(ctrl_current_report)) else $error("self rep");
  chk_report_bus: assert property (
    !self_powered[*4] ##0 reg_rd_en && reg_addr == 8'h0f && !$past(reg_wr_en)
    |=> reg_rd_data == $past(ctrl_current_report)) else $error("bus rep");
  chk_lang_upper: assert property (
    reg_wr_en && reg_addr == 8'h11
    |=> language_code[15:8] == $past(reg_wr_data)) else $error("lang hi");
  chk_lang_lower: assert property (
    reg_wr_en && reg_addr == 8'h12
    |=> language_code[7:0] == $past(reg_wr_data)) else $error("lang lo");
  chk_len_clamp: assert property (
    reg_wr_en && reg_addr == 8'h13 |=> maker_text_length ==
    ($past(reg_wr_data) > 8'h1f ? 8'h1f : $past(reg_wr_data)))
    else $error("len clamp");
  chk_delay_store: assert property (
    reg_wr_en && reg_addr == 8'h10
    |=> port_power_good_delay == $past(reg_wr_data)) else $error("delay");
  chk_pg_zero: assert property (
    port_power_start && port_power_good_delay == 8'h00 && !reg_wr_en
    ##1 !port_power_start |=> port_power_good) else $error("pg zero");
endmodule

bind hcps_config_regs hcps_config_regs_asserts #(
  .PG_TICK_CYCLES(PG_TICK_CYCLES)) u_chk (.clk, .rst_n, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .self_powered,
  .ctrl_current_report, .language_code, .maker_text_length,
  .port_power_start, .port_power_good_delay, .port_power_good);

/* File: sim/hcps_loader_model.sv */
// Loader model: configuration memory or management host on the byte port.
// Assumes a read answers one cycle after it is taken.
`timescale 1ns/1ps
module hcps_loader_model (
  input wire logic clk,
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wr_data = 8'h00,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wr_data = ~d;
    q = reg_rd_valid ? reg_rd_data : 8'hxx;
  endtask
  task automatic put_char(input logic [4:0] n, input logic [15:0] c);
    logic [7:0] q;
    xfer(1'b1, 8'h16 + {2'b00, n, 1'b0}, c[7:0], q);
    xfer(1'b1, 8'h17 + {2'b00, n, 1'b0}, c[15:8], q);
  endtask
endmodule

/* File: sim/test_hub_config_power_string_regs.sv */
// Bench for the hub configuration bank driven through the loader model.
// Assumes a 4-cycle power-good tick.
`timescale 1ns/1ps
module test_hub_config_power_string_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic self_powered = 1'b1;
  logic port_power_start = 1'b0;
  logic [4:0] char_index = 5'h00;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, port_power_good;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, ctrl_current_report;
  logic [15:0] char_data;
  logic [15:0] lang;
  logic [7:0] lens [3];
  logic [31:0] seed = 32'h9ee88324;
  logic [15:0] txt [32];
  int n_errors = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  hcps_config_regs #(.PG_TICK_CYCLES(4)) DUT (.clk, .rst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
    .self_powered, .ctrl_current_report, .language_code(lang),
    .maker_text_length(lens[0]), .item_text_length(lens[1]),
    .serial_text_length(lens[2]),
    .char_index, .char_data, .port_power_start, .port_power_good_delay(),
    .port_power_good);
  hcps_loader_model host (.clk, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wr_data, .reg_rd_data, .reg_rd_valid);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] s, u, b;
    int e;
    int c;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.xfer(1'b0, 8'h0f, 8'h00, b);
    chk("bus cur", b, 8'h32);
    for (int i = 0; i < 4; i++) begin
      s = 8'(rnd() % 51);
      u = (i == 0) ? 8'h32 : 8'(rnd() % 51);
      host.xfer(1'b1, 8'h0e, s, b);
      host.xfer(1'b1, 8'h0f, u, b);
      self_powered = i[0];
      repeat (4) @(posedge clk);
      host.xfer(1'b0, 8'h0e, 8'h00, b);
      chk("self cur", b, s);
      host.xfer(1'b0, 8'h0f, 8'h00, b);
      chk("bus cur", b, u);
      chk("report", ctrl_current_report, i[0] ? s : u);
    end
    s = 8'(rnd());
    u = 8'(rnd());
    host.xfer(1'b1, 8'h11, s, b);
    host.xfer(1'b1, 8'h12, u, b);
    chk("language", lang, {s, u});
    for (int k = 0; k < 9; k++) begin
      s = (k < 3) ? 8'(rnd()) : (k < 6) ? 8'h1f : 8'h20;
      u = 8'(8'h13 + k % 3);
      host.xfer(1'b1, u, s, b);
      host.xfer(1'b0, u, 8'h00, b);
      chk("length", b, (s > 8'h1f) ? 8'h1f : s);
      chk("length out", lens[k % 3], (s > 8'h1f) ? 8'h1f : s);
    end
    for (int i = 0; i < 31; i++) begin
      txt[i] = 16'(rnd());
      host.put_char(5'(i), txt[i]);
    end
    for (int i = 0; i < 32; i++) begin
      char_index = 5'(i);
      @(posedge clk);
      #1;
      chk("char", char_data, (i < 31) ? txt[i] : 16'h0000);
    end
    host.xfer(1'b0, 8'h17, 8'h00, b);
    chk("text byte", b, txt[0][15:8]);
    host.xfer(1'b1, 8'h54, 8'(rnd()), b);
    host.xfer(1'b0, 8'h54, 8'h00, b);
    chk("unmapped", b, 8'h00);
    for (int d = 0; d < 3; d += 2) begin
      host.xfer(1'b1, 8'h10, 8'(d), b);
      port_power_start = 1'b1;
      @(posedge clk);
      #1;
      port_power_start = 1'b0;
      c = 0;
      while (port_power_good !== 1'b1 && c < 99) begin
        @(posedge clk);
        #1;
        c++;
      end
      e = (d == 0) ? 2 : d * 4 + 1;
      chk("pg time", 16'(c >= e - 1 && c <= e + 1), 16'h0001);
    end
    wrap_up();
  end
endmodule
